// file: core/cotr_pkg.sv
package cotr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int unsigned N_TRIM = 4;
  localparam int unsigned N_CORE = 3;
  localparam int unsigned TRIM_W = 12;
  localparam int unsigned REG_W = 16;
  localparam int unsigned IDX_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_A_SECOND = 8'h8c;
  localparam logic [7:0] IDX_C_FIRST = 8'h8e;
  localparam logic [7:0] IDX_C_SECOND = 8'h90;
  localparam logic [7:0] IDX_B_FIRST = 8'h92;
  localparam logic [7:0] IDX_STATUS = 8'ha0;
  localparam logic [21:0] ADDR_HIGH_ZERO = 22'h000000;

  // Storage slots of the trim bank
  localparam logic [1:0] SLOT_A_SECOND = 2'h0;
  localparam logic [1:0] SLOT_C_FIRST = 2'h1;
  localparam logic [1:0] SLOT_C_SECOND = 2'h2;
  localparam logic [1:0] SLOT_B_FIRST = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Field layout and reset values
  localparam int unsigned TRIM_MSB = 11;
  localparam int unsigned RSVD_MSB = 15;
  localparam int unsigned RSVD_LSB = 12;
  localparam logic [3:0] RSVD_RESET = 4'h0;
  localparam logic [11:0] TRIM_RESET = 12'h000;

  // Status register bit positions
  localparam int unsigned ST_FG_RUNNING = 0;
  localparam int unsigned ST_OS_EN = 1;
  localparam int unsigned ST_BG_EN = 2;
  localparam int unsigned ST_BGOS_EN = 3;
  localparam int unsigned ST_FOREGROUND_CAL_COMPLETE = 4;
  localparam int unsigned ST_BG_PAUSED = 5;
  localparam int unsigned ST_LOADED = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Core pairing map, bit index is the core
  localparam int unsigned CORE_A = 0;
  localparam int unsigned CORE_B = 1;
  localparam int unsigned CORE_C = 2;
  localparam logic [2:0] FIRST_COVERED = 3'h6;
  localparam logic [2:0] SECOND_COVERED = 3'h5;
  localparam logic [2:0][1:0] FIRST_SLOT =
    {SLOT_C_FIRST, SLOT_B_FIRST, SLOT_A_SECOND};
  localparam logic [2:0][1:0] SECOND_SLOT =
    {SLOT_C_SECOND, SLOT_B_FIRST, SLOT_A_SECOND};

  ////////////////////////////////////////////////////////////////////////////
  // Bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef logic [15:0] cotr_trim_t;
  typedef cotr_trim_t [3:0] cotr_bank_t;
  typedef logic [2:0][11:0] cotr_core_trim_t;

  typedef struct packed {
    logic fg_running;
    logic offset_cal_enable;
    logic background_cal_enable;
    logic background_offset_cal_enable;
    logic foreground_cal_complete;
    logic background_cal_paused;
  } cotr_cal_t;

  typedef struct packed {
    logic en;
    logic [7:0] idx;
    logic [15:0] data;
  } cotr_wr_t;

  typedef struct packed {
    logic take;
    logic [7:0] idx;
  } cotr_rd_t;

  typedef enum logic [1:0] {
    AP_IDLE = 2'b00,
    AP_WRITE = 2'b01,
    AP_READ = 2'b11
  } cotr_phase_t;

endpackage

// file: core/cotr_ahb_port.sv
`timescale 1ns/10ps
`default_nettype none
module cotr_ahb_port (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Address and data phase
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  // Decoded accesses
  output cotr_pkg::cotr_wr_t wr,
  output cotr_pkg::cotr_rd_t rd
);

  typedef struct packed {
    cotr_pkg::cotr_phase_t ph;
    logic [7:0] idx;
  } cotr_ap_state_t;

  cotr_ap_state_t st;
  cotr_ap_state_t next_st;
  logic take;

  ////////////////////////////////////////////////////////////////////////////
  // Only whole-word single transfers are decoded; others fall to idle
  always_comb
  begin
    take = hsel && hready && (htrans == cotr_pkg::HTRANS_NONSEQ)
      && (hsize == cotr_pkg::HSIZE_WORD);
    next_st = st;
    if (hready)
    begin
      next_st.ph = cotr_pkg::AP_IDLE;
      if (take)
      begin
        next_st.ph = hwrite ? cotr_pkg::AP_WRITE : cotr_pkg::AP_READ;
        next_st.idx = (haddr[31:10] == cotr_pkg::ADDR_HIGH_ZERO)
          ? haddr[9:2] : 8'hff;
      end
    end
    rd.take = take && !hwrite;
    rd.idx = (haddr[31:10] == cotr_pkg::ADDR_HIGH_ZERO) ? haddr[9:2] : 8'hff;
    wr.en = (st.ph == cotr_pkg::AP_WRITE) && hready;
    wr.idx = st.idx;
    wr.data = hwdata[15:0];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st <= '{ph: cotr_pkg::AP_IDLE, idx: 8'h00};
    else
      st <= next_st;
  end

endmodule
`default_nettype wire

// file: core/cotr_select.sv
`timescale 1ns/10ps
`default_nettype none
module cotr_select (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Trim bank and pairing
  input wire cotr_pkg::cotr_bank_t bank,
  input wire logic [2:0] sample_second,
  // Applied trims
  output cotr_pkg::cotr_core_trim_t core_trim,
  output logic [2:0] core_trim_valid
);

  typedef struct packed {
    cotr_pkg::cotr_core_trim_t trim;
    logic [2:0] valid;
  } cotr_sel_state_t;

  cotr_sel_state_t st;
  cotr_sel_state_t next_st;

  ////////////////////////////////////////////////////////////////////////////
  // Re-evaluated every cycle, so a pairing change lands one edge later
  for (genvar c = 0; c < 3; c++)
  begin : g_core
    always_comb
    begin
      if (sample_second[c])
      begin
        next_st.trim[c] = bank[cotr_pkg::SECOND_SLOT[c]][11:0];
        next_st.valid[c] = cotr_pkg::SECOND_COVERED[c];
      end
      else
      begin
        next_st.trim[c] = bank[cotr_pkg::FIRST_SLOT[c]][11:0];
        next_st.valid[c] = cotr_pkg::FIRST_COVERED[c];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign core_trim = st.trim;
  assign core_trim_valid = st.valid;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_core_a_second: assert property (
    sample_second[0] |=> core_trim_valid[0]
      && core_trim[0] == $past(bank[0][11:0]))
    else $error("core A second input trim not applied");
  a_core_a_first: assert property (
    !sample_second[0] |=> !core_trim_valid[0])
    else $error("core A trim applied on first input");
  a_core_c_first: assert property (
    !sample_second[2] |=> core_trim_valid[2]
      && core_trim[2] == $past(bank[1][11:0]))
    else $error("core C first input trim wrong");
  a_core_c_second: assert property (
    sample_second[2] |=> core_trim_valid[2]
      && core_trim[2] == $past(bank[2][11:0]))
    else $error("core C second input trim wrong");
  a_core_b_first: assert property (
    !sample_second[1] |=> core_trim_valid[1]
      && core_trim[1] == $past(bank[3][11:0]))
    else $error("core B first input trim wrong");
  a_pair_follow: assert property (
    $changed(sample_second) |=> core_trim_valid
      == (($past(sample_second) & 3'h5) | (~$past(sample_second) & 3'h6)))
    else $error("applied trim did not follow pairing change");

  c_core_c_swap: cover property (!sample_second[2] ##1 sample_second[2]);
  c_all_second: cover property (sample_second == 3'h7);

endmodule
`default_nettype wire

// file: core/cotr_top.sv
// What this block does
// - Each trim register keeps its correction, unsigned, in bits 11 to 0.
// - Bits 15 to 12 are spare, read and write, reset to zero.
// - After reset each trim shows its factory value; host may overwrite.
// - Core A second input trim applies only while A samples input two.
// - Trim at 0x08e applies while core C samples the first input.
// - Trim at 0x090 applies while core C samples the second input.
// - Trim at 0x092 applies while core B samples the first input.
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module cotr_top (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Factory trims and calibration state
  input wire logic [3:0][11:0] factory_trim,
  input wire cotr_pkg::cotr_cal_t cal,
  // Sampling pairing, one bit per core, high for the second input
  input wire logic [2:0] sample_second,
  // Applied trims per core
  output cotr_pkg::cotr_core_trim_t core_trim,
  output logic [2:0] core_trim_valid
);

  typedef struct packed {
    cotr_pkg::cotr_bank_t bank;
    logic loaded;
    logic [31:0] rdata;
    logic readyout;
    logic resp;
  } cotr_top_state_t;

  cotr_top_state_t st;
  cotr_top_state_t next_st;
  cotr_pkg::cotr_wr_t wr;
  cotr_pkg::cotr_rd_t rd;
  logic [6:0] status;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  cotr_ahb_port u_port (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .wr(wr),
    .rd(rd)
  );

  function automatic logic [2:0] slot_of(input logic [7:0] idx);
    logic [2:0] s;
    s = 3'h4;
    case (idx)
      cotr_pkg::IDX_A_SECOND: s = {1'b0, cotr_pkg::SLOT_A_SECOND};
      cotr_pkg::IDX_C_FIRST: s = {1'b0, cotr_pkg::SLOT_C_FIRST};
      cotr_pkg::IDX_C_SECOND: s = {1'b0, cotr_pkg::SLOT_C_SECOND};
      cotr_pkg::IDX_B_FIRST: s = {1'b0, cotr_pkg::SLOT_B_FIRST};
      default: s = 3'h4;
    endcase
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register file and read path
  always_comb
  begin
    logic [2:0] ws;
    logic [2:0] rs;
    ws = slot_of(wr.idx);
    rs = slot_of(rd.idx);
    next_st = st;
    status = {st.loaded, cal.background_cal_paused,
      cal.foreground_cal_complete, cal.background_offset_cal_enable,
      cal.background_cal_enable, cal.offset_cal_enable, cal.fg_running};
    // Factory values land on the first edge after reset release
    if (!st.loaded)
    begin
      for (int i = 0; i < 4; i++)
        next_st.bank[i] = {cotr_pkg::RSVD_RESET, factory_trim[i]};
      next_st.loaded = 1'b1;
    end
    // Whole 16 bits stored, spare nibble included; no lockout during cal
    // since the host is trusted to keep off the bank while it runs
    if (wr.en && !ws[2])
      next_st.bank[ws[1:0]] = wr.data;
    // Reads return the bank as seen after a write finishing this cycle
    if (rd.take)
    begin
      next_st.rdata = 32'h00000000;
      if (!rs[2])
      begin
        if (wr.en && wr.idx == rd.idx)
          next_st.rdata[15:0] = wr.data;
        else
          next_st.rdata[15:0] = st.bank[rs[1:0]];
      end
      else if (rd.idx == cotr_pkg::IDX_STATUS)
        next_st.rdata[6:0] = status;
    end
    next_st.readyout = 1'b1;
    next_st.resp = cotr_pkg::HRESP_OKAY;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st.bank <= {4{cotr_pkg::RSVD_RESET, cotr_pkg::TRIM_RESET}};
      st.loaded <= 1'b0;
      st.rdata <= 32'h00000000;
      st.readyout <= 1'b1;
      st.resp <= cotr_pkg::HRESP_OKAY;
    end
    else
      st <= next_st;
  end

  assign hreadyout = st.readyout;
  assign hresp = st.resp;
  assign hrdata = st.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Per-core application of the bank
  cotr_select u_select (
    .hclk(hclk),
    .hresetn(hresetn),
    .bank(st.bank),
    .sample_second(sample_second),
    .core_trim(core_trim),
    .core_trim_valid(core_trim_valid)
  );

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_trim_write: assert property (
    (wr.en && wr.idx == cotr_pkg::IDX_C_FIRST && st.loaded)
      |=> st.bank[1][11:0] == $past(wr.data[11:0]))
    else $error("trim field did not take written value");
  a_rsvd_reset: assert property (
    $rose(st.loaded) |-> st.bank[0][15:12] == 4'h0
      && st.bank[1][15:12] == 4'h0 && st.bank[2][15:12] == 4'h0
      && st.bank[3][15:12] == 4'h0)
    else $error("spare bits not zero after reset");
  a_rsvd_write: assert property (
    (wr.en && wr.idx == cotr_pkg::IDX_B_FIRST && st.loaded)
      |=> st.bank[3][15:12] == $past(wr.data[15:12]))
    else $error("spare bits not writable");
  a_factory_load: assert property (
    $rose(st.loaded) |-> st.bank[2][11:0] == $past(factory_trim[2])
      && st.bank[0][11:0] == $past(factory_trim[0]))
    else $error("factory trim not loaded after reset");
  a_read_back: assert property (
    (rd.take && rd.idx == cotr_pkg::IDX_A_SECOND && !wr.en && st.loaded)
      |=> hrdata == {16'h0000, $past(st.bank[0])})
    else $error("read data differs from trim bank");
  a_always_ready: assert property (
    hreadyout && hresp == cotr_pkg::HRESP_OKAY)
    else $error("slave stalled or answered with error");

  c_write_read: cover property (wr.en ##1 rd.take);
  c_status_read: cover property (rd.take && rd.idx == cotr_pkg::IDX_STATUS);
  c_back_to_back: cover property (
    wr.en && rd.take && wr.idx == rd.idx);

endmodule
`default_nettype wire

// file: sim/cotr_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module cotr_host_model (
  // Clock and bus answer
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // Calibration view
  input wire cotr_pkg::cotr_cal_t cal,
  // Bus request
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trim access only when calibration leaves it safe
  function automatic logic may_write();
    return !cal.fg_running &&
      !(cal.background_cal_enable && cal.background_offset_cal_enable);
  endfunction

  function automatic logic may_read();
    logic ok;
    ok = 1'b1;
    if (cal.offset_cal_enable && !cal.background_offset_cal_enable)
      ok = cal.foreground_cal_complete;
    if (cal.background_cal_enable && cal.background_offset_cal_enable)
      ok = cal.background_cal_paused;
    return ok;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Caller enters just after a rising edge, so transfers run back to back
  task automatic xfer(input logic wr, input logic [7:0] idx,
    input logic [31:0] wd, output logic ok, output logic [31:0] rd);
    logic trim;
    trim = (idx != cotr_pkg::IDX_STATUS);
    ok = !trim || (wr ? may_write() : may_read());
    rd = 32'h0;
    if (ok)
    begin
      hsel <= 1'b1;
      haddr <= {22'h0, idx, 2'h0};
      htrans <= cotr_pkg::HTRANS_NONSEQ;
      hwrite <= wr;
      hsize <= cotr_pkg::HSIZE_WORD;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
    end
  endtask
endmodule
`default_nettype wire

// file: sim/cotr_top_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module cotr_top_tb_top;
  logic hclk = 1'b0;
  logic hresetn;
  logic [3:0][11:0] factory_trim;
  cotr_pkg::cotr_cal_t cal;
  logic [2:0] sample_second;
  wire logic hsel, hwrite, hreadyout, hresp;
  wire logic [1:0] htrans;
  wire logic [2:0] hsize;
  wire logic [31:0] haddr, hwdata, hrdata;
  wire cotr_pkg::cotr_core_trim_t core_trim;
  wire logic [2:0] core_trim_valid;
  int num_errors = 0;
  int n_compared = 0;
  logic [15:0] lfsr = 16'h1f7e;
  logic [15:0] bank [4];
  logic [7:0] tidx [4] = '{8'h8c, 8'h8e, 8'h90, 8'h92};
  logic [7:0] ctab [5] = '{8'h60, 8'h0c, 8'h4d, 8'h90, 8'hd2};
  logic [31:0] exp_q [$];
  logic rd_pend = 1'b0;

  always #2.5 hclk = ~hclk;

  cotr_host_model u_host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
    .cal(cal), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  cotr_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .factory_trim(factory_trim),
    .cal(cal), .sample_second(sample_second), .core_trim(core_trim),
    .core_trim_valid(core_trim_valid));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("Compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Read data is judged in its data phase against the oldest note
  always @(posedge hclk)
  begin
    if (rd_pend && hreadyout === 1'b1)
      check(hrdata, exp_q.size() > 0 ? exp_q.pop_front() : 32'hdead);
    rd_pend <= hsel && htrans == cotr_pkg::HTRANS_NONSEQ && !hwrite;
  end

  // Refused or unmapped accesses leave the bank model untouched
  task automatic acc(input logic wr, input logic [7:0] idx,
    input logic [31:0] wd, input logic exp_ok, input logic [31:0] exp_rd);
    logic ok;
    logic [31:0] rdv;
    if (!wr && exp_ok)
      exp_q.push_back(exp_rd);
    u_host.xfer(wr, idx, wd, ok, rdv);
    check({31'h0, ok}, {31'h0, exp_ok});
    for (int i = 0; i < 4; i++)
      if (wr && ok && idx == tidx[i])
        bank[i] = wd[15:0];
  endtask

  task automatic do_reset();
    logic [15:0] r;
    @(posedge hclk);
    hresetn <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      r = rnd();
      factory_trim[i] <= r[11:0];
      bank[i] = {4'h0, r[11:0]};
    end
    repeat (4) @(posedge hclk);
    check({hreadyout, hresp, 27'h0, core_trim_valid}, 32'h80000000);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask

  // Core A only on input two, B only on input one, C on both
  task automatic chk_apply();
    logic [2:0] s;
    s = sample_second;
    check({29'h0, core_trim_valid}, {29'h0, 1'b1, ~s[1], s[0]});
    if (s[0])
      check({20'h0, core_trim[0]}, {20'h0, bank[0][11:0]});
    if (!s[1])
      check({20'h0, core_trim[1]}, {20'h0, bank[3][11:0]});
    if (s[2])
      check({20'h0, core_trim[2]}, {20'h0, bank[2][11:0]});
    else
      check({20'h0, core_trim[2]}, {20'h0, bank[1][11:0]});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    hresetn = 1'b0;
    cal = '0;
    sample_second = 3'h0;
    factory_trim = '0;
    do_reset();
    for (int i = 0; i < 4; i++)
      acc(1'b0, tidx[i], 32'h0, 1'b1, {16'h0, bank[i]});
    $display("test factory done");
    for (int i = 0; i < 4; i++)
    begin
      acc(1'b1, tidx[i], {rnd(), rnd()}, 1'b1, 32'h0);
      acc(1'b0, tidx[i], 32'h0, 1'b1, {16'h0, bank[i]});
    end
    // Unmapped place drops writes and reads zero
    acc(1'b1, 8'h8d, 32'hffffffff, 1'b1, 32'h0);
    acc(1'b0, 8'h8d, 32'h0, 1'b1, 32'h0);
    acc(1'b0, 8'h94, 32'h0, 1'b1, 32'h0);
    $display("test access done");
    for (int v = 0; v < 8; v++)
    begin
      sample_second <= v[2:0];
      repeat (2) @(posedge hclk);
      chk_apply();
    end
    $display("test pairing done");
    for (int i = 0; i < 5; i++)
    begin
      cal <= cotr_pkg::cotr_cal_t'(ctab[i][5:0]);
      @(posedge hclk);
      acc(1'b0, cotr_pkg::IDX_STATUS, 32'h0, 1'b1,
        {25'h0, 1'b1, ctab[i][0], ctab[i][1], ctab[i][2], ctab[i][3],
        ctab[i][4], ctab[i][5]});
      acc(1'b1, tidx[1], {rnd(), rnd()}, ctab[i][7], 32'h0);
      acc(1'b0, tidx[1], 32'h0, ctab[i][6], {16'h0, bank[1]});
    end
    $display("test calibration done");
    cal <= '0;
    do_reset();
    for (int i = 0; i < 4; i++)
      acc(1'b0, tidx[i], 32'h0, 1'b1, {16'h0, bank[i]});
    repeat (3) @(posedge hclk);
    chk_apply();
    $display("test second reset done");
    finish_test();
  end

  // Whole run is under a hundred cycles
  initial
  begin
    #100000;
    num_errors++;
    finish_test();
  end
endmodule
`default_nettype wire
